//--- src/srme_top.sv
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Supervisor-only setting makes user accesses ignored, left for outside decoding.
// - Byte, word and long-word reads and writes reach registers and array.
// - Byte or aligned word access completes in one two-clock bus cycle.
// - Long-word access runs as two consecutive bus cycles, one per word.
// - Coprocessor has no array path or influence during normal operation.
// - Array refuses all accesses while running from the standby supply.
// - Stop bit set gives low-power stop: contents kept, array access blocked.
// - Stop bit may be written only by a supervisor-mode processor.
// - Every reset sets the stop bit; writing it zero leaves stop mode.
// - Reset restricts to supervisor, clears base register, disables the array.
// - Reset during a byte or word access waits until that access finishes.
// - Reset during a long word's first half finishes it, skips the second.
// - Reset during a long word's second half finishes the whole access.
// - Emulation fetches return array data with the microcode ROM timing.
// - Emulation mode ignores internal bus accesses; control registers have no effect.
// - Base bits compare with address 23 to 12; a match below page offset E00 selects the array.
// - Disable flag set after reset, cleared by a valid base, kept on overlap.
// - Only the first base register write after reset is taken.
// - Control block is eight bytes; unimplemented parts read zero, ignore writes.
module srme_top #(
	parameter logic [23:0] CTRL_BASE_ADDR = srme_pkg::CTRL_BASE,
	parameter int          DEPTH          = srme_pkg::ARRAY_WORDS
) (
	input  wire logic                        clock_i,
	input  wire logic                        resetn_i,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [srme_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]                 pwdata_i,
	input  wire logic [3:0]                  pstrb_i,
	input  wire logic [2:0]                  pprot_i,
	input  wire logic [1:0]                  transfer_size_i,
	output logic [31:0]                      prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o,
	output logic                             claim_o,
	input  wire logic                        standby_power_i,
	input  wire logic                        emulation_mode_i,
	input  wire logic                        cop_fetch_i,
	input  wire logic [srme_pkg::WIDX_W-1:0] cop_addr_i,
	output logic [31:0]                      cop_data_o,
	output logic                             cop_valid_o
);
	srme_pkg::srme_state_t st_q;
	srme_pkg::srme_state_t st_d;
	logic [1:0]  beat_q;
	logic [1:0]  beat_d;
	logic        long_q;
	logic        err_q;
	logic        err_d;
	logic [31:0] rdata_q;
	logic        stop_q;
	logic        asel_q;
	logic [11:0] base_q;
	logic        dis_q;
	logic        bar_locked_q;
	logic        stby_s1_q;
	logic        stby_s2_q;
	logic        stby_s3_q;
	logic        stby_q;
	wire  [31:0] arr_word;
	wire  [31:0] cop_word;

	// Reset is held off until no transfer is in flight
	wire rst_apply = !resetn_i && (st_q == srme_pkg::SRME_IDLE);
	wire start     = resetn_i && psel_i && penable_i && (st_q == srme_pkg::SRME_IDLE);
	wire sup_mode  = pprot_i[0];
	wire is_long   = (transfer_size_i == srme_pkg::SIZ_LONG);

	wire ctrl_hit  = (paddr_i[23:3] == CTRL_BASE_ADDR[23:3]);
	wire arr_page  = (paddr_i[23:12] == base_q) && (paddr_i[11:0] < srme_pkg::ARRAY_BYTES);
	wire arr_hit   = arr_page && !dis_q && !ctrl_hit;
	wire reg_ok    = ctrl_hit && sup_mode && !emulation_mode_i;
	wire arr_ok    = arr_hit && (sup_mode || !asel_q) && !stop_q && !stby_q && !emulation_mode_i;
	wire accept    = reg_ok || arr_ok;

	wire         word_done  = (st_q == srme_pkg::SRME_BUSY) &&
		((beat_q == srme_pkg::BEAT_FIRST) || (beat_q == srme_pkg::BEAT_SECOND));
	wire         second     = (beat_q == srme_pkg::BEAT_SECOND);
	// Long word writes each half in its own bus cycle
	wire [3:0]   cur_lanes  = !long_q ? pstrb_i :
		(second ? (pstrb_i & srme_pkg::LANES_HI) : (pstrb_i & srme_pkg::LANES_LO));
	wire         wr_now     = word_done && pwrite_i;
	wire         reg_wr     = wr_now && ctrl_hit;
	wire         mcr_sel    = (paddr_i[2:0] == srme_pkg::MCR_OFS);
	wire         bar_sel    = (paddr_i[2:0] == srme_pkg::BAR_OFS);
	wire [srme_pkg::WIDX_W-1:0] widx = paddr_i[11:2];

	wire [31:0]  mcr_word   = {16'h0000, stop_q, asel_q, 14'h0000};
	wire [31:0]  bar_word   = {16'h0000, base_q, 3'h0, dis_q};
	wire [31:0]  reg_word   = mcr_sel ? mcr_word : (bar_sel ? bar_word : 32'h0000_0000);
	wire [31:0]  src_word   = ctrl_hit ? reg_word : arr_word;

	// Base write merges only the strobed lanes; unwritten half stays reset
	wire [11:0]  base_new   = {cur_lanes[1] ? pwdata_i[15:8] : base_q[11:4],
		cur_lanes[0] ? pwdata_i[7:4] : base_q[3:0]};
	wire         bar_wr     = reg_wr && bar_sel && (cur_lanes[1:0] != 2'b00) && !bar_locked_q;
	wire         mcr_wr_hi  = reg_wr && mcr_sel && cur_lanes[1] && sup_mode;

	always_comb
	begin
		st_d   = st_q;
		beat_d = beat_q;
		err_d  = err_q;
		unique case (st_q)
			srme_pkg::SRME_IDLE:
			begin
				if (start)
				begin
					beat_d = srme_pkg::BEAT_FIRST;
					err_d  = !accept;
					st_d   = accept ? srme_pkg::SRME_BUSY : srme_pkg::SRME_END;
				end
			end
			srme_pkg::SRME_BUSY:
			begin
				if (beat_q == srme_pkg::BEAT_FIRST && long_q)
				begin
					// Reset in the first half ends the long word after it
					if (resetn_i)
					begin
						beat_d = srme_pkg::BEAT_MID;
					end
					else
					begin
						err_d = 1'b1;
						st_d  = srme_pkg::SRME_END;
					end
				end
				else if (beat_q == srme_pkg::BEAT_MID)
				begin
					beat_d = srme_pkg::BEAT_SECOND;
				end
				else
				begin
					st_d = srme_pkg::SRME_END;
				end
			end
			srme_pkg::SRME_END:
			begin
				st_d = srme_pkg::SRME_IDLE;
			end
			default:
			begin
				st_d = srme_pkg::SRME_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		st_q   <= st_d;
		beat_q <= beat_d;
		err_q  <= err_d;
		if (start)
		begin
			long_q <= is_long;
		end
		if (rst_apply)
		begin
			st_q   <= srme_pkg::SRME_IDLE;
			beat_q <= srme_pkg::BEAT_FIRST;
			err_q  <= 1'b0;
			long_q <= 1'b0;
		end
	end

	// Read data: whole word for short access, per half for long
	always_ff @(posedge clock_i)
	begin
		if (rst_apply || start)
		begin
			rdata_q <= 32'h0000_0000;
		end
		else if (word_done && !pwrite_i)
		begin
			if (!long_q)
			begin
				rdata_q <= src_word;
			end
			else if (second)
			begin
				rdata_q[31:16] <= src_word[31:16];
			end
			else
			begin
				rdata_q[15:0] <= src_word[15:0];
			end
		end
	end

	assign prdata_o  = rdata_q;
	assign pready_o  = (st_q == srme_pkg::SRME_END);
	assign pslverr_o = (st_q == srme_pkg::SRME_END) && err_q;
	assign claim_o   = (st_q != srme_pkg::SRME_IDLE) && !err_q;

	// Control registers: reset effects apply once the bus is quiet
	always_ff @(posedge clock_i)
	begin
		if (rst_apply)
		begin
			stop_q       <= srme_pkg::STOP_RST;
			asel_q       <= srme_pkg::ASEL_RST;
			base_q       <= srme_pkg::BASE_RST;
			dis_q        <= srme_pkg::DIS_RST;
			bar_locked_q <= 1'b0;
		end
		else
		begin
			if (mcr_wr_hi)
			begin
				stop_q <= pwdata_i[srme_pkg::STOP_BIT];
				asel_q <= pwdata_i[srme_pkg::ASEL_BIT];
			end
			if (bar_wr)
			begin
				base_q       <= base_new;
				bar_locked_q <= 1'b1;
				// Overlap with the control block keeps the array off
				dis_q        <= (base_new == CTRL_BASE_ADDR[23:12]);
			end
		end
	end

	// Array split into byte lanes so each lane has a single writing process
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_lane
			logic [7:0] lane_mem [DEPTH];
			always_ff @(posedge clock_i)
			begin
				if (wr_now && !ctrl_hit && cur_lanes[g])
				begin
					lane_mem[widx] <= pwdata_i[8*g +: 8];
				end
			end
			assign arr_word[8*g +: 8] = lane_mem[widx];
			assign cop_word[8*g +: 8] = lane_mem[cop_addr_i];
		end
	endgenerate

	// Standby supply indicator from the power switch
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			stby_s1_q <= 1'b0;
			stby_s2_q <= 1'b0;
			stby_s3_q <= 1'b0;
			stby_q    <= 1'b0;
		end
		else
		begin
			stby_s1_q <= standby_power_i;
			stby_s2_q <= stby_s1_q;
			stby_s3_q <= stby_s2_q;
			if (stby_s2_q == stby_s3_q)
			begin
				stby_q <= stby_s3_q;
			end
		end
	end

	// Coprocessor fetch port: one-clock latency like the microcode ROM.
	// Stop and disable are ignored here since control registers have no effect.
	wire cop_ok = cop_fetch_i && emulation_mode_i && !stby_q;

	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			cop_valid_o <= 1'b0;
			cop_data_o  <= 32'h0000_0000;
		end
		else
		begin
			cop_valid_o <= cop_ok;
			if (cop_ok)
			begin
				cop_data_o <= cop_word;
			end
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	a_user_ignored: assert property ((start && ctrl_hit && !sup_mode) |=> (pready_o && pslverr_o))
		else $error("user access to control block was claimed");
	a_short_timing: assert property ((start && accept && !is_long) |=>
		(!pready_o ##1 (pready_o && !pslverr_o)))
		else $error("short access did not end after two clocks");
	a_long_timing: assert property ((start && accept && is_long) |=>
		(!pready_o [*3] ##1 (pready_o && !pslverr_o)))
		else $error("long access did not take two bus cycles");
	a_stop_blocks: assert property ((start && arr_hit && stop_q) |=> pslverr_o)
		else $error("array reached in stop mode");
	a_standby_blocks: assert property ((start && arr_hit && stby_q) |=> pslverr_o)
		else $error("array reached on standby power");
	a_emu_inhibit: assert property ((start && emulation_mode_i) |=> (pslverr_o && !claim_o))
		else $error("bus access answered in emulation mode");
	a_cop_normal: assert property ((!emulation_mode_i) |=> !cop_valid_o)
		else $error("coprocessor fetch served in normal mode");
	a_bar_locked: assert property (bar_locked_q |=> ($stable(base_q) && $stable(dis_q)))
		else $error("base register changed after lock");
	a_refused_quiet: assert property (pslverr_o |-> (prdata_o == 32'h0000_0000 && !claim_o))
		else $error("refused access drove data or claim");
endmodule

//--- src/srme_pkg.sv
package srme_pkg;
	// Geometry
	localparam int          ADDR_W       = 24;
	localparam int          ARRAY_WORDS  = 896;
	localparam int          WIDX_W       = 10;
	localparam logic [11:0] ARRAY_BYTES  = 12'hE00;
	localparam logic [23:0] CTRL_BASE    = 24'hFFFB00;
	// Register offsets inside the eight-byte control block
	localparam logic [2:0]  MCR_OFS      = 3'h0;
	localparam logic [2:0]  BAR_OFS      = 3'h4;
	// Field positions
	localparam int          STOP_BIT     = 15;
	localparam int          ASEL_BIT     = 14;
	localparam int          BASE_HI      = 15;
	localparam int          BASE_LO      = 4;
	localparam int          DIS_BIT      = 0;
	// Reset values
	localparam logic        STOP_RST     = 1'b1;
	localparam logic        ASEL_RST     = 1'b1;
	localparam logic [11:0] BASE_RST     = 12'h000;
	localparam logic        DIS_RST      = 1'b1;
	// Transfer size codes
	localparam logic [1:0]  SIZ_LONG     = 2'h0;
	localparam logic [1:0]  SIZ_BYTE     = 2'h1;
	localparam logic [1:0]  SIZ_WORD     = 2'h2;
	// Lane groups of the two word halves of a long word
	localparam logic [3:0]  LANES_LO     = 4'h3;
	localparam logic [3:0]  LANES_HI     = 4'hC;
	// Beat counter values: end of first bus cycle, start of second, end of second
	localparam logic [1:0]  BEAT_FIRST   = 2'h0;
	localparam logic [1:0]  BEAT_MID     = 2'h1;
	localparam logic [1:0]  BEAT_SECOND  = 2'h2;

	typedef enum logic [1:0] {
		SRME_IDLE = 2'b00,
		SRME_BUSY = 2'b01,
		SRME_END  = 2'b10
	} srme_state_t;
endpackage

//--- verif/srme_cop_model.sv
`timescale 1ns/1ps
module srme_cop_model (
	input  wire logic                        clock_i,
	input  wire logic                        emu_req_i,
	input  wire logic                        fetch_req_i,
	input  wire logic [srme_pkg::WIDX_W-1:0] idx_i,
	output logic                             emulation_mode_o = 1'b0,
	output logic                             cop_fetch_o = 1'b0,
	output logic [srme_pkg::WIDX_W-1:0]      cop_addr_o = '0
);
	// Idle address toggles so a stale index can never pass for a fetch
	always @(posedge clock_i)
	begin
		emulation_mode_o <= emu_req_i;
		cop_fetch_o      <= fetch_req_i;
		cop_addr_o       <= fetch_req_i ? idx_i : ~cop_addr_o;
	end
endmodule

//--- verif/srme_tb_top.sv
`timescale 1ns/1ps
module standby_ram_with_microcode_emulation_tb_top;
	localparam logic [23:0] MCR_A = srme_pkg::CTRL_BASE + {21'h0, srme_pkg::MCR_OFS};
	localparam logic [23:0] BAR_A = srme_pkg::CTRL_BASE + {21'h0, srme_pkg::BAR_OFS};
	localparam logic [23:0] ARR_A = 24'h012000;
	localparam logic [1:0]  LW    = srme_pkg::SIZ_LONG;
	localparam logic [1:0]  WD    = srme_pkg::SIZ_WORD;
	logic        clock_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        standby = 1'b0, emu_req = 1'b0, fetch_req = 1'b0, emu, cfetch;
	logic        pready, pslverr, claim, cop_valid, e;
	logic [23:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, cop_data, junk, mem [0:895];
	logic [3:0]  pstrb = '0;
	logic [2:0]  pprot = '0;
	logic [1:0]  tsize = '0;
	logic [9:0]  fidx = '0, caddr;
	int          fails = 0, checks_done = 0, n, idx, k;
	logic [1:0]  z;
	logic [3:0]  s;

	srme_cop_model COP (.clock_i(clock_i), .emu_req_i(emu_req), .fetch_req_i(fetch_req),
		.idx_i(fidx), .emulation_mode_o(emu), .cop_fetch_o(cfetch), .cop_addr_o(caddr));
	srme_top DUT (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.pprot_i(pprot), .transfer_size_i(tsize), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .claim_o(claim), .standby_power_i(standby),
		.emulation_mode_i(emu), .cop_fetch_i(cfetch), .cop_addr_i(caddr),
		.cop_data_o(cop_data), .cop_valid_o(cop_valid));

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] sb);
		for (int b = 0; b < 4; b++)
			if (sb[b])
				o[b*8 +: 8] = d[b*8 +: 8];
		return o;
	endfunction

	function automatic logic [31:0] lat_of(input logic er, input logic [1:0] zz);
		return er ? 32'h2 : (zz == LW ? 32'h5 : 32'h3);
	endfunction

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		checks_done++;
		if (g !== ex)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, g);
		end
	endtask

	task automatic end_of_test();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Outputs are read right after the rising edge, before the slave's registers update
	task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d,
		input logic [3:0] sb, input logic [1:0] zz, input logic sup, input int ra,
		output logic [31:0] rd, output logic er, output int cnt);
		cnt = 0;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		pstrb  <= sb;
		tsize  <= zz;
		pprot  <= {2'h0, sup};
		@(posedge clock_i);
		penable <= 1'b1;
		do
		begin
			@(posedge clock_i);
			cnt++;
			if (cnt == ra)
				resetn_i <= 1'b0;
		end
		while (pready !== 1'b1 && cnt < 40);
		rd = prdata;
		er = pslverr;
		if (ra == 0)
			chk("claim", {31'h0, ~er}, {31'h0, claim});
		psel    <= 1'b0;
		penable <= 1'b0;
		if (ra != 0)
			repeat (2) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
	endtask

	task automatic op(input logic w, input logic [23:0] a, input logic [31:0] d,
		input logic [3:0] sb, input logic [1:0] zz, input logic sup, input logic ee);
		apb(w, a, d, sb, zz, sup, 0, junk, e, n);
		chk("slverr", {31'h0, ee}, {31'h0, e});
		chk("latency", lat_of(ee, zz), n);
	endtask

	task automatic rdc(input logic [23:0] a, input logic [1:0] zz, input logic sup,
		input logic ee, input logic [31:0] ex);
		op(1'b0, a, 32'h0, 4'hF, zz, sup, ee);
		chk("rdata", ex, junk);
	endtask

	task automatic init();
		op(1'b1, BAR_A, 32'h00000120, 4'h3, WD, 1'b1, 1'b0);
		op(1'b1, MCR_A, 32'h00000000, 4'h3, WD, 1'b1, 1'b0);
	endtask

	task automatic fetch(input int i, input logic [31:0] ev, input logic [31:0] ex);
		logic [31:0] v;
		v = '0;
		fidx      <= i[9:0];
		fetch_req <= 1'b1;
		@(posedge clock_i);
		fetch_req <= 1'b0;
		for (int c = 0; c < 4; c++)
		begin
			@(negedge clock_i);
			v[c] = cop_valid;
			if (cop_valid === 1'b1)
				chk("cop_data", ex, cop_data);
		end
		chk("cop_valid", ev, v);
		@(posedge clock_i);
	endtask

	initial
	begin
		forever #12.5 clock_i = ~clock_i;
	end

	initial
	begin
		#(25ns * 20000);
		fails++;
		end_of_test();
	end

	initial
	begin
		void'($urandom(32'hE7E794FE));
		repeat (4) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		rdc(MCR_A, WD, 1'b1, 1'b0, 32'h0000C000);
		rdc(BAR_A, WD, 1'b1, 1'b0, 32'h00000001);
		rdc(ARR_A, LW, 1'b1, 1'b1, 32'h0);
		op(1'b1, MCR_A, 32'h0, 4'h3, WD, 1'b0, 1'b1);
		rdc(MCR_A, WD, 1'b1, 1'b0, 32'h0000C000);
		rdc(srme_pkg::CTRL_BASE + 24'h8, WD, 1'b1, 1'b1, 32'h0);
		op(1'b1, srme_pkg::CTRL_BASE + 24'h2, 32'h0000FFFF, 4'h3, WD, 1'b1, 1'b0);
		rdc(srme_pkg::CTRL_BASE + 24'h2, WD, 1'b1, 1'b0, 32'h0);
		op(1'b1, BAR_A, 32'h00000120, 4'h3, WD, 1'b1, 1'b0);
		op(1'b1, BAR_A, 32'h00000340, 4'h3, WD, 1'b1, 1'b0);
		rdc(BAR_A, WD, 1'b1, 1'b0, 32'h00000120);
		rdc(ARR_A, LW, 1'b1, 1'b1, 32'h0);
		op(1'b1, MCR_A, 32'h00004000, 4'h3, WD, 1'b1, 1'b0);
		rdc(ARR_A, LW, 1'b0, 1'b1, 32'h0);
		op(1'b1, MCR_A, 32'h0, 4'h3, WD, 1'b1, 1'b0);
		for (int i = 0; i < 16; i++)
		begin
			idx = (i < 8) ? i : 880 + i;
			mem[idx] = $urandom;
			op(1'b1, ARR_A + 24'(idx * 4), mem[idx], 4'hF, LW, 1'b1, 1'b0);
		end
		for (int i = 0; i < 80; i++)
		begin
			k = $urandom % 16;
			idx = (k < 8) ? k : 880 + k;
			z = 2'($urandom % 3);
			s = (z == LW) ? 4'hF : (z == WD) ? (($urandom % 2) ? 4'h3 : 4'hC)
				: 4'(4'h1 << ($urandom % 4));
			if ($urandom % 2)
			begin
				pwdata <= $urandom;
				@(posedge clock_i);
				mem[idx] = merge(mem[idx], pwdata, s);
				op(1'b1, ARR_A + 24'(idx * 4), pwdata, s, z, 1'($urandom), 1'b0);
			end
			else
				rdc(ARR_A + 24'(idx * 4), LW, 1'($urandom), 1'b0, mem[idx]);
		end
		rdc(ARR_A + 24'h001000, LW, 1'b1, 1'b1, 32'h0);
		standby <= 1'b1;
		repeat (8) @(posedge clock_i);
		rdc(ARR_A, LW, 1'b1, 1'b1, 32'h0);
		emu_req <= 1'b1;
		repeat (3) @(posedge clock_i);
		fetch(1, 32'h0, 32'h0);
		standby <= 1'b0;
		emu_req <= 1'b1;
		repeat (8) @(posedge clock_i);
		rdc(ARR_A, LW, 1'b1, 1'b1, 32'h0);
		op(1'b1, MCR_A, 32'h00008000, 4'h3, WD, 1'b1, 1'b1);
		fetch(2, 32'h2, mem[2]);
		fetch(895, 32'h2, mem[895]);
		emu_req <= 1'b0;
		repeat (3) @(posedge clock_i);
		rdc(MCR_A, WD, 1'b1, 1'b0, 32'h0);
		fetch(3, 32'h0, 32'h0);
		mem[3] = merge(mem[3], 32'hA5A55A5A, 4'h3);
		apb(1'b1, ARR_A + 24'hC, 32'hA5A55A5A, 4'h3, WD, 1'b1, 1, junk, e, n);
		chk("slverr", 32'h0, {31'h0, e});
		rdc(MCR_A, WD, 1'b1, 1'b0, 32'h0000C000);
		init();
		rdc(ARR_A + 24'hC, LW, 1'b1, 1'b0, mem[3]);
		mem[4] = merge(mem[4], 32'h12345678, 4'h3);
		apb(1'b1, ARR_A + 24'h10, 32'h12345678, 4'hF, LW, 1'b1, 1, junk, e, n);
		chk("slverr", 32'h1, {31'h0, e});
		init();
		rdc(ARR_A + 24'h10, LW, 1'b1, 1'b0, mem[4]);
		mem[5] = 32'h9ABCDEF0;
		apb(1'b1, ARR_A + 24'h14, mem[5], 4'hF, LW, 1'b1, 2, junk, e, n);
		chk("slverr", 32'h0, {31'h0, e});
		init();
		rdc(ARR_A + 24'h14, LW, 1'b1, 1'b0, mem[5]);
		apb(1'b0, MCR_A, 32'h0, 4'h3, WD, 1'b1, 1, junk, e, n);
		op(1'b1, BAR_A, 32'h0000FFF0, 4'h3, WD, 1'b1, 1'b0);
		rdc(BAR_A, WD, 1'b1, 1'b0, 32'h0000FFF1);
		end_of_test();
	end
endmodule
